// file: design/uef_pkg.sv
// Purpose: Shared constants and carriers for the USB endpoint FIFO status block.
// Assumes: A 10 MHz system clock and the CPU special register port.
// Notes: Register numbers are the CPU's 4-bit register file addresses.
package uef_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam real SUSP_IDLE_MS = 3.0;
    // A least time, so the cycle count rounds up.
    localparam int SUSP_IDLE_CYC = int'($ceil(SUSP_IDLE_MS * CLK_HZ / 1000.0));

    localparam int FIFO_AW = 5;
    localparam int FIFO_DEPTH = 1 << FIFO_AW;
    localparam int BYTE_W = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Bank 0 register numbers.
    localparam logic [3:0] ADDR_APP_STATUS = 4'h0C;
    localparam logic [3:0] ADDR_FIFO_PTR = 4'h0D;
    localparam logic [3:0] ADDR_FIFO_DATA = 4'h0E;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h0F;
    // Bank 1 register number.
    localparam logic [3:0] ADDR_CONV_TOKEN = 4'h0A;

    // Application status register fields.
    localparam int STS_STALL = 0;
    localparam int STS_BUSY = 1;
    localparam int STS_IDLE = 2;
    localparam int STS_WAKE = 3;
    localparam int STS_TX1 = 5;
    localparam int STS_TX0 = 6;
    localparam int STS_RXF = 7;

    // Interrupt status register fields.
    localparam int IRQ_TIMER = 0;
    localparam int IRQ_EP0 = 1;
    localparam int IRQ_SUSPEND = 2;
    localparam int IRQ_BUS_RESET = 3;
    localparam int IRQ_RESUME = 4;
    localparam int IRQ_PORT = 5;
    localparam int IRQ_PAT_HIGH = 6;
    localparam int IRQ_PAT_LOW = 7;

    // Converter channel and token register fields.
    localparam int CONV_CH_MSB = 4;
    localparam int CONV_TOKEN = 6;
    localparam int CONV_READY = 7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bank1;
        logic [3:0] addr;
        logic [7:0] wdata;
    } uef_cpu_req_t;

    typedef struct packed {
        logic bus_activity;
        logic timer_ovf;
        logic ep0_cmd;
        logic bus_reset;
        logic port_change;
        logic pat_high;
        logic pat_low;
        logic token;
        logic setup_ok;
    } uef_evt_t;

    typedef struct packed {
        logic rx_wr;
        logic [4:0] rx_addr;
        logic [7:0] rx_data;
        logic rx_done;
        logic [1:0] tx_done;
        logic busy;
    } uef_eng_t;

endpackage

// file: design/uef_core.sv
// Purpose: Firmware side status flags, FIFO pointer and data port of the
//          low-speed USB device engine.
// Assumes: All inputs are synchronous to clk_i; event inputs are pulses.
// Notes: Register reads return data one cycle after the read strobe.
// Functional notes
// RULE1 - Idle flag after 3.0 ms quiet bus
// RULE2 - Wakeup request set by firmware, cleared on resume
// RULE3 - Transmit requests set by firmware, engine clears
// RULE4 - Firmware checks transmit request before loading FIFO
// RULE5 - Engine sets receive-full, then blocked until cleared
// RULE6 - Firmware sets receive-full before writing FIFO
// RULE7 - Pointer is five bits, upper bits zero
// RULE8 - Data port accesses byte at pointer
// RULE9 - Timer overflow flag sticky until cleared
// RULE10 - Endpoint zero command flag, firmware clears
// RULE11 - Suspend flag set on suspend detect
// RULE12 - Bus reset flag set on host reset
// RULE13 - Resume flag on suspend fall, slow mode only
// RULE14 - Port change flag on line state change
// RULE15 - Top two flags are pattern counter flags
// RULE16 - Token bit latched by hardware, firmware clears
// RULE17 - Stall request cleared by successful setup
// RULE18 - Busy bit shows engine FIFO access
// RULE19 - Hardware set beats firmware clear
// RULE20 - Everything resets to zero; the FIFO array and the engine read data register are not reset
module uef_core #(
    parameter int IDLE_CYCLES_P = uef_pkg::SUSP_IDLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire uef_pkg::uef_cpu_req_t cpu_i,
    output logic [7:0] cpu_rdata_o,
    input wire uef_pkg::uef_evt_t evt_i,
    input wire logic slow_clock_i,
    input wire uef_pkg::uef_eng_t eng_i,
    input wire logic [4:0] eng_rd_addr_i,
    output logic [7:0] eng_rd_data_o,
    output logic eng_rx_ready_o,
    output logic [1:0] tx_req_o,
    output logic stall_o,
    output logic remote_wakeup_o,
    output logic bus_idle_o
);
    import uef_pkg::*;

    localparam int CW = $clog2(IDLE_CYCLES_P + 1);
    localparam logic [CW-1:0] IDLE_MAX = CW'(IDLE_CYCLES_P);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    logic [BYTE_W-1:0] fifo_mem [FIFO_DEPTH];

    logic [CW-1:0] idle_cnt_q, idle_cnt_d;
    logic idle_q, idle_d;
    logic stall_q, stall_d;
    logic wake_q, wake_d;
    logic [1:0] tx_q, tx_d;
    logic rxf_q, rxf_d;
    logic [FIFO_AW-1:0] ptr_q, ptr_d;
    logic [7:0] irq_q, irq_d;
    logic tok_q, tok_d;
    logic [CONV_CH_MSB:0] conv_ch_q, conv_ch_d;
    logic conv_rdy_q, conv_rdy_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] eng_rdata_q;

    logic wr_b0, wr_sts, wr_ptr, wr_dat, wr_irq, wr_conv;
    logic eng_wr_ok, idle_rise, idle_fall;
    logic [7:0] irq_set, sts_view;

    assign wr_b0 = cpu_i.wr && !cpu_i.bank1;
    assign wr_sts = wr_b0 && cpu_i.addr == ADDR_APP_STATUS;
    assign wr_ptr = wr_b0 && cpu_i.addr == ADDR_FIFO_PTR;
    assign wr_dat = wr_b0 && cpu_i.addr == ADDR_FIFO_DATA;
    assign wr_irq = wr_b0 && cpu_i.addr == ADDR_IRQ_STATUS;
    assign wr_conv = cpu_i.wr && cpu_i.bank1 && cpu_i.addr == ADDR_CONV_TOKEN;

    // The engine may only fill the FIFO while receive-full is clear.
    assign eng_wr_ok = eng_i.rx_wr && !rxf_q; // RULE5 RULE6

    // Bus idle detection.
    always_comb begin
        idle_cnt_d = idle_cnt_q;
        idle_d = idle_q;
        if (evt_i.bus_activity) begin
            idle_cnt_d = '0; // RULE1
            idle_d = 1'b0; // RULE1
        end else if (idle_cnt_q != IDLE_MAX) begin
            idle_cnt_d = idle_cnt_q + CNT_ONE;
            idle_d = (idle_cnt_d == IDLE_MAX); // RULE1
        end
    end

    assign idle_rise = !idle_q && idle_d;
    assign idle_fall = idle_q && !idle_d;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_TIMER] = evt_i.timer_ovf; // RULE9
        irq_set[IRQ_EP0] = evt_i.ep0_cmd; // RULE10
        irq_set[IRQ_SUSPEND] = idle_rise; // RULE11
        irq_set[IRQ_BUS_RESET] = evt_i.bus_reset; // RULE12
        irq_set[IRQ_RESUME] = idle_fall && slow_clock_i; // RULE13
        irq_set[IRQ_PORT] = evt_i.port_change; // RULE14
        irq_set[IRQ_PAT_HIGH] = evt_i.pat_high; // RULE15
        irq_set[IRQ_PAT_LOW] = evt_i.pat_low; // RULE15
    end

    always_comb begin
        sts_view = '0;
        sts_view[STS_STALL] = stall_q;
        sts_view[STS_BUSY] = eng_i.busy; // RULE18
        sts_view[STS_IDLE] = idle_q;
        sts_view[STS_WAKE] = wake_q;
        sts_view[STS_TX1] = tx_q[1];
        sts_view[STS_TX0] = tx_q[0];
        sts_view[STS_RXF] = rxf_q;
    end

    // Flag updates; every hardware set is ORed in after the firmware write.
    always_comb begin
        stall_d = stall_q;
        wake_d = wake_q;
        tx_d = tx_q;
        rxf_d = rxf_q;
        ptr_d = ptr_q;
        irq_d = irq_q | irq_set; // RULE19
        tok_d = tok_q;
        conv_ch_d = conv_ch_q;
        conv_rdy_d = conv_rdy_q;
        if (evt_i.setup_ok) begin
            stall_d = 1'b0; // RULE17
        end
        if (idle_fall) begin
            wake_d = 1'b0; // RULE2
        end
        tx_d = tx_q & ~eng_i.tx_done; // RULE3
        if (wr_sts) begin
            // A write of zero never clears the set-only bits.
            stall_d = cpu_i.wdata[STS_STALL];
            wake_d = wake_d | cpu_i.wdata[STS_WAKE]; // RULE2
            tx_d[0] = tx_d[0] | cpu_i.wdata[STS_TX0]; // RULE3
            tx_d[1] = tx_d[1] | cpu_i.wdata[STS_TX1]; // RULE3
            rxf_d = cpu_i.wdata[STS_RXF]; // RULE6
        end
        if (eng_i.rx_done) begin
            rxf_d = 1'b1; // RULE5 RULE19
        end
        if (wr_ptr) begin
            ptr_d = cpu_i.wdata[FIFO_AW-1:0]; // RULE7
        end
        if (wr_irq) begin
            irq_d = cpu_i.wdata | irq_set; // RULE19
        end
        if (wr_conv) begin
            tok_d = cpu_i.wdata[CONV_TOKEN];
            conv_ch_d = cpu_i.wdata[CONV_CH_MSB:0];
            conv_rdy_d = cpu_i.wdata[CONV_READY];
        end
        if (evt_i.token) begin
            tok_d = 1'b1; // RULE16 RULE19
        end
    end

    // Read data, registered for one cycle.
    always_comb begin
        rdata_d = rdata_q;
        if (cpu_i.rd) begin
            rdata_d = RESET_BYTE;
            if (cpu_i.bank1) begin
                if (cpu_i.addr == ADDR_CONV_TOKEN) begin
                    rdata_d[CONV_CH_MSB:0] = conv_ch_q;
                    rdata_d[CONV_TOKEN] = tok_q;
                    rdata_d[CONV_READY] = conv_rdy_q;
                end
            end else begin
                unique case (cpu_i.addr)
                    ADDR_APP_STATUS: rdata_d = sts_view;
                    ADDR_FIFO_PTR: rdata_d[FIFO_AW-1:0] = ptr_q; // RULE7
                    ADDR_FIFO_DATA: rdata_d = fifo_mem[ptr_q]; // RULE8
                    ADDR_IRQ_STATUS: rdata_d = irq_q;
                    default: rdata_d = RESET_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idle_cnt_q <= '0; // RULE20
            idle_q <= 1'b0;
            stall_q <= 1'b0;
            wake_q <= 1'b0;
            tx_q <= '0;
            rxf_q <= 1'b0;
            ptr_q <= '0;
            irq_q <= RESET_BYTE;
            tok_q <= 1'b0;
            conv_ch_q <= '0;
            conv_rdy_q <= 1'b0;
            rdata_q <= RESET_BYTE;
        end else begin
            idle_cnt_q <= idle_cnt_d;
            idle_q <= idle_d;
            stall_q <= stall_d;
            wake_q <= wake_d;
            tx_q <= tx_d;
            rxf_q <= rxf_d;
            ptr_q <= ptr_d;
            irq_q <= irq_d;
            tok_q <= tok_d;
            conv_ch_q <= conv_ch_d;
            conv_rdy_q <= conv_rdy_d;
            rdata_q <= rdata_d;
        end
    end

    // The FIFO array holds no reset; only its pointer is cleared.
    always_ff @(posedge clk_i) begin
        if (eng_wr_ok) begin
            fifo_mem[eng_i.rx_addr] <= eng_i.rx_data; // RULE5
        end else if (wr_dat) begin
            fifo_mem[ptr_q] <= cpu_i.wdata; // RULE8
        end
        eng_rdata_q <= fifo_mem[eng_rd_addr_i]; // RULE3
    end

    assign cpu_rdata_o = rdata_q;
    assign eng_rd_data_o = eng_rdata_q;
    assign eng_rx_ready_o = !rxf_q;
    assign tx_req_o = tx_q;
    assign stall_o = stall_q;
    assign remote_wakeup_o = wake_q;
    assign bus_idle_o = idle_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_IDLE_SET: assert property ( // RULE1
        (idle_cnt_q == IDLE_MAX - CNT_ONE && !idle_q && !evt_i.bus_activity)
        |=> bus_idle_o)
        else $error("Idle flag missed the quiet time.");
    AST_IDLE_CLR: assert property ( // RULE1
        evt_i.bus_activity |=> !bus_idle_o && idle_cnt_q == '0)
        else $error("Idle flag not cleared by activity.");
    AST_WAKE_CLR: assert property ( // RULE2
        (bus_idle_o && evt_i.bus_activity && !wr_sts) |=> !remote_wakeup_o)
        else $error("Wakeup request survived the resume.");
    AST_TX_CLR: assert property ( // RULE3
        (eng_i.tx_done[0] && !wr_sts) |=> !tx_req_o[0])
        else $error("Transmit request not cleared by engine.");
    AST_RX_FULL: assert property ( // RULE5
        eng_i.rx_done |=> !eng_rx_ready_o ##1 ($past(wr_sts) || !eng_rx_ready_o))
        else $error("Receive-full not held after engine write.");
    // Compared with the low five bits of the written byte, so a dropped pointer write shows up.
    AST_PTR: assert property ( // RULE7
        (wr_ptr ##1 !wr_ptr ##1 (cpu_i.rd && !cpu_i.bank1
            && cpu_i.addr == ADDR_FIFO_PTR && !wr_ptr))
        |=> cpu_rdata_o == {3'h0, $past(cpu_i.wdata[FIFO_AW-1:0], 3)})
        else $error("Pointer readback wrong.");
    AST_TIMER: assert property ( // RULE9
        evt_i.timer_ovf |=> irq_q[IRQ_TIMER])
        else $error("Timer flag lost.");
    AST_RESUME: assert property ( // RULE13
        (idle_fall && !slow_clock_i && !irq_q[IRQ_RESUME] && !wr_irq)
        |=> !irq_q[IRQ_RESUME])
        else $error("Resume flag set outside slow mode.");
    AST_TOKEN: assert property ( // RULE16
        evt_i.token |=> tok_q)
        else $error("Token bit lost.");
    AST_STALL: assert property ( // RULE17
        (evt_i.setup_ok && !wr_sts) |=> !stall_o)
        else $error("Stall not cleared on setup.");
    AST_TIMER_HOLD: assert property ( // RULE9
        (irq_q[IRQ_TIMER] && !wr_irq) |=> irq_q[IRQ_TIMER])
        else $error("Timer flag dropped without a write.");
    AST_EP0_CMD: assert property ( // RULE10
        evt_i.ep0_cmd |=> irq_q[IRQ_EP0])
        else $error("Endpoint zero command flag lost.");
    AST_SUSPEND: assert property ( // RULE11
        $rose(bus_idle_o) |-> irq_q[IRQ_SUSPEND])
        else $error("Suspend flag missed the idle rise.");
    AST_BUS_RESET: assert property ( // RULE12
        evt_i.bus_reset |=> irq_q[IRQ_BUS_RESET])
        else $error("Bus reset flag lost.");
    AST_PORT: assert property ( // RULE14
        evt_i.port_change |=> irq_q[IRQ_PORT])
        else $error("Port change flag lost.");
    AST_PAT_LOW: assert property ( // RULE15
        evt_i.pat_low |=> irq_q[IRQ_PAT_LOW])
        else $error("Low pattern flag lost.");
    // Firmware must never be able to withdraw a wakeup request.
    AST_WAKE_HOLD: assert property ( // RULE2
        (remote_wakeup_o && !(bus_idle_o && evt_i.bus_activity))
        |=> remote_wakeup_o)
        else $error("Wakeup request dropped before resume.");
    AST_TX_HOLD: assert property ( // RULE3
        (tx_req_o[1] && !eng_i.tx_done[1]) |=> tx_req_o[1])
        else $error("Transmit request dropped before the fetch.");
    AST_TOK_HOLD: assert property ( // RULE16
        (tok_q && !wr_conv) |=> tok_q)
        else $error("Token bit dropped without a write.");

endmodule

// file: tb/uef_engine_model.sv
// Purpose: Behavioural USB engine on the far side of the FIFO status block.
// Assumes: Drives on falling edges; eng_rd_data_o lags its address a cycle.
// Notes: Waits an extra cycle on fetches to behave like a slow engine.
module uef_engine_model
    import uef_pkg::*;
(
    input wire logic clk_i,
    input wire logic rx_ready_i,
    input wire logic [1:0] tx_req_i,
    input wire logic [7:0] rd_data_i,
    output uef_eng_t eng_o,
    output logic [4:0] rd_addr_o,
    output logic [7:0] last_tx_o
);
    timeunit 1ns;
    timeprecision 1ns;

    task automatic fetch(input int ep);
        eng_o.busy = 1'b1;
        rd_addr_o = (ep == 1) ? 5'h10 : 5'h00;
        repeat (2) @(negedge clk_i);
        last_tx_o = rd_data_i;
        eng_o.tx_done[ep] = 1'b1;
        @(negedge clk_i);
        eng_o.tx_done = 2'h0;
        eng_o.busy = 1'b0;
        rd_addr_o = ~rd_addr_o;
    endtask

    task automatic rx_packet(input logic [4:0] a, input logic [7:0] d,
                             output logic ok);
        int n;
        n = 0;
        // The engine must not overwrite data firmware has not collected.
        while (rx_ready_i !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        ok = (n < 50);
        if (ok) begin
            eng_o.busy = 1'b1;
            eng_o.rx_wr = 1'b1;
            eng_o.rx_addr = a;
            eng_o.rx_data = d;
            @(negedge clk_i);
            eng_o.rx_wr = 1'b0;
            eng_o.rx_data = ~d;
            eng_o.rx_done = 1'b1;
            @(negedge clk_i);
            eng_o.rx_done = 1'b0;
            eng_o.busy = 1'b0;
        end
    endtask

    initial begin
        eng_o = '0;
        rd_addr_o = 5'h00;
        last_tx_o = 8'h00;
        forever begin
            @(negedge clk_i);
            if (tx_req_i[0] === 1'b1) begin
                fetch(0);
            end else if (tx_req_i[1] === 1'b1) begin
                fetch(1);
            end
        end
    end
endmodule

// file: tb/usb_endpoint_fifo_status_tb.sv
// Purpose: Self-checking bench for the FIFO status core.
// Assumes: Idle count shortened to 20 cycles.
// Notes: Bus activity is pulsed every 8 cycles unless keep is low.
module usb_endpoint_fifo_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import uef_pkg::*;

    localparam int IDLE_SIM = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic slow = 1'b0;
    logic keep = 1'b1;
    logic ok;
    logic [2:0] ka = 3'h0;
    logic [8:0] ev = 9'h000;
    uef_cpu_req_t cpu = '0;
    uef_evt_t evt;
    uef_eng_t eng;
    logic [4:0] era;
    logic [7:0] rdata, erd, last_tx, rv;
    logic rxr, stall, wake, idle;
    logic [1:0] txr;
    int bad_count = 0;
    int tests_run = 0;
    int n;

    always #50 clk_i = ~clk_i;
    always @(negedge clk_i) ka <= ka + 3'h1;
    assign evt = uef_evt_t'(ev | {keep && ka == 3'h0, 8'h00});

    uef_core #(.IDLE_CYCLES_P(IDLE_SIM)) uef_core_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .cpu_i(cpu), .cpu_rdata_o(rdata), .evt_i(evt),
        .slow_clock_i(slow), .eng_i(eng), .eng_rd_addr_i(era),
        .eng_rd_data_o(erd), .eng_rx_ready_o(rxr), .tx_req_o(txr),
        .stall_o(stall), .remote_wakeup_o(wake), .bus_idle_o(idle));
    uef_engine_model uef_engine_model_i (.clk_i(clk_i), .rx_ready_i(rxr),
        .tx_req_i(txr), .rd_data_i(erd), .eng_o(eng), .rd_addr_o(era),
        .last_tx_o(last_tx));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic b, input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_i);
        cpu = '{wr: 1'b1, rd: 1'b0, bank1: b, addr: a, wdata: d};
        @(negedge clk_i);
        cpu.wr = 1'b0;
    endtask

    task automatic rd(input logic b, input logic [3:0] a);
        @(negedge clk_i);
        cpu = '{wr: 1'b0, rd: 1'b1, bank1: b, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        cpu.rd = 1'b0;
        rv = rdata;
    endtask

    task automatic pulse(input int i);
        @(negedge clk_i);
        ev[i] = 1'b1;
        @(negedge clk_i);
        ev[i] = 1'b0;
    endtask

    task automatic t_reset;
        logic [3:0] ra [5];
        ra = '{ADDR_APP_STATUS, ADDR_FIFO_PTR, ADDR_IRQ_STATUS, 4'h0B,
               ADDR_CONV_TOKEN};
        for (int i = 0; i < 5; i++) begin
            rd(i == 4, ra[i]);
            check(rv, 8'h00);
        end
        check({7'h00, rxr}, 8'h01);
    endtask

    task automatic t_pointer;
        wr(0, ADDR_FIFO_PTR, 8'hFF);
        rd(0, ADDR_FIFO_PTR);
        check(rv, 8'h1F);
        wr(0, ADDR_FIFO_PTR, 8'h05);
        wr(0, ADDR_FIFO_DATA, 8'h5A);
        wr(0, ADDR_FIFO_PTR, 8'h06);
        wr(0, ADDR_FIFO_DATA, 8'hC3);
        wr(0, ADDR_FIFO_PTR, 8'h05);
        rd(0, ADDR_FIFO_DATA);
        check(rv, 8'h5A);
    endtask

    task automatic t_tx(input int ep);
        logic [7:0] m;
        m = (ep == 1) ? 8'h20 : 8'h40;
        wr(0, ADDR_APP_STATUS, 8'h80);
        rd(0, ADDR_APP_STATUS);
        check(rv & m, 8'h00);
        wr(0, ADDR_FIFO_PTR, (ep == 1) ? 8'h10 : 8'h00);
        wr(0, ADDR_FIFO_DATA, 8'hA0 + 8'(ep));
        wr(0, ADDR_APP_STATUS, 8'h80 | m);
        check({6'h00, txr}, (ep == 1) ? 8'h02 : 8'h01);
        n = 0;
        while (txr !== 2'h0 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        if (txr !== 2'h0) begin
            bad_count++;
            finish_test();
        end
        check(last_tx, 8'hA0 + 8'(ep));
        wr(0, ADDR_APP_STATUS, 8'h00);
    endtask

    task automatic t_rx;
        uef_engine_model_i.rx_packet(5'h09, 8'h3C, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            finish_test();
        end
        rd(0, ADDR_APP_STATUS);
        check(rv & 8'h80, 8'h80);
        check({7'h00, rxr}, 8'h00);
        wr(0, ADDR_FIFO_PTR, 8'h09);
        rd(0, ADDR_FIFO_DATA);
        check(rv, 8'h3C);
        wr(0, ADDR_APP_STATUS, 8'h00);
        check({7'h00, rxr}, 8'h01);
    endtask

    task automatic t_irq;
        int evi [6];
        int bit_no [6];
        evi = '{7, 6, 5, 4, 3, 2};
        bit_no = '{0, 1, 3, 5, 6, 7};
        for (int i = 0; i < 6; i++) begin
            wr(0, ADDR_IRQ_STATUS, 8'h00);
            pulse(evi[i]);
            rd(0, ADDR_IRQ_STATUS);
            check(rv, 8'h01 << bit_no[i]);
        end
        wr(0, ADDR_IRQ_STATUS, 8'h01);
        @(negedge clk_i);
        ev[7] = 1'b1;
        cpu = '{wr: 1'b1, rd: 1'b0, bank1: 1'b0, addr: ADDR_IRQ_STATUS,
                wdata: 8'h00};
        @(negedge clk_i);
        ev[7] = 1'b0;
        cpu.wr = 1'b0;
        rd(0, ADDR_IRQ_STATUS);
        check(rv, 8'h01);
        wr(0, ADDR_IRQ_STATUS, 8'h00);
        rd(0, ADDR_IRQ_STATUS);
        check(rv, 8'h00);
    endtask

    task automatic t_idle;
        slow = 1'b1;
        keep = 1'b0;
        // One known activity pulse makes the quiet time start at a fixed edge.
        pulse(8);
        n = 0;
        while (idle !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        check(8'(n), 8'(IDLE_SIM));
        rd(0, ADDR_APP_STATUS);
        check(rv & 8'h04, 8'h04);
        rd(0, ADDR_IRQ_STATUS);
        check(rv, 8'h04);
        wr(0, ADDR_APP_STATUS, 8'h08);
        wr(0, ADDR_APP_STATUS, 8'h00);
        check({7'h00, wake}, 8'h01);
        pulse(8);
        @(negedge clk_i);
        check({6'h00, idle, wake}, 8'h00);
        rd(0, ADDR_IRQ_STATUS);
        check(rv, 8'h14);
        slow = 1'b0;
        repeat (IDLE_SIM + 1) @(negedge clk_i);
        check({7'h00, idle}, 8'h01);
        wr(0, ADDR_IRQ_STATUS, 8'h00);
        pulse(8);
        rd(0, ADDR_IRQ_STATUS);
        check(rv, 8'h00);
        keep = 1'b1;
    endtask

    task automatic t_token_stall;
        pulse(1);
        rd(1, ADDR_CONV_TOKEN);
        check(rv & 8'h40, 8'h40);
        wr(1, ADDR_CONV_TOKEN, 8'h00);
        rd(1, ADDR_CONV_TOKEN);
        check(rv, 8'h00);
        wr(0, ADDR_APP_STATUS, 8'h01);
        check({7'h00, stall}, 8'h01);
        pulse(0);
        check({7'h00, stall}, 8'h00);
    endtask

    initial begin
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset();
        t_pointer();
        t_tx(0);
        t_tx(1);
        t_rx();
        t_irq();
        t_idle();
        t_token_stall();
        finish_test();
    end
endmodule
